// ---- aphc_regs.svh ----
// Control-byte fields, modes and timing counts for the converter control block.
`ifndef APHC_REGS_SVH
`define APHC_REGS_SVH

`define APHC_BIT_PWR_HI      7
`define APHC_BIT_PWR_LO      6
`define APHC_BIT_ACQ_MODE    5
`define APHC_BIT_RANGE       4
`define APHC_BIT_BIPOLAR     3
`define APHC_CHAN_MSB        2
`define APHC_CHAN_LSB        0
`define APHC_CHAN_LAST       3'h5
`define APHC_CTRL_RESET      8'h00
`define APHC_ACQ_CYCLES      6
`define APHC_CONV_BITS       12
`define APHC_CORE_CLK_KHZ    40000
`define APHC_OSC_KHZ         1560
`define APHC_OSC_HALF_CYCLES ((`APHC_CORE_CLK_KHZ + 2 * `APHC_OSC_KHZ - 1) / (2 * `APHC_OSC_KHZ))

`endif

// ---- aphc_pkg.sv ----
// Types shared by the converter control block.
package aphc_pkg;

	typedef enum logic [1:0] {
		APHC_MODE_EXT_CLK = 2'b00,
		APHC_MODE_INT_CLK = 2'b01,
		APHC_MODE_STANDBY = 2'b10,
		APHC_MODE_FULL_PD = 2'b11
	} aphc_mode_type;

	typedef enum logic [2:0] {
		APHC_ST_IDLE    = 3'b000,
		APHC_ST_ACQ_INT = 3'b001,
		APHC_ST_ACQ_EXT = 3'b010,
		APHC_ST_CONVERT = 3'b011,
		APHC_ST_DONE    = 3'b100
	} aphc_state_type;

endpackage

// ---- aphc_tick_if.sv ----
// Converter tick carrier between the tick generator and the sequencer.
`timescale 1ns/1ps

interface aphc_tick_if;
	logic use_internal;
	logic tick;

	modport source (input use_internal, output tick);
	modport sink   (output use_internal, input tick);
endinterface

// ---- aphc_tick_gen.sv ----
// Converter clock tick generator: synchronised pin clock or internal oscillator.
`timescale 1ns/1ps
`include "aphc_regs.svh"

module aphc_tick_gen #(
	parameter int HALF_CYCLES = `APHC_OSC_HALF_CYCLES
) (
	// Clock and reset.
	input  wire logic     core_clk,
	input  wire logic     rst_n,
	// Converter clock pin.
	input  wire logic     conv_clk_pin,
	// Tick carrier.
	aphc_tick_if.source   tick_port
);
	import aphc_pkg::*;

	logic [2:0]  pin_sync_q;
	logic        pin_level_q;
	logic [15:0] osc_cnt_q;
	logic        osc_tick;

	// =====================================================================
	// Pin clock synchroniser: a level counts once stages two and three agree.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], conv_clk_pin};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_level_q <= 1'b0;
		end else if (pin_sync_q[1] == pin_sync_q[2]) begin
			pin_level_q <= pin_sync_q[2];
		end
	end

	// =====================================================================
	// Internal oscillator: one tick per full period at about 1.56 MHz.
	assign osc_tick = (osc_cnt_q == 16'(2 * HALF_CYCLES - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_cnt_q <= 16'h0;
		end else if (!tick_port.use_internal || osc_tick) begin
			osc_cnt_q <= 16'h0;
		end else begin
			osc_cnt_q <= osc_cnt_q + 16'h1;
		end
	end

	// Rising edge of the pin clock, or the oscillator tick.
	assign tick_port.tick = tick_port.use_internal ? osc_tick
		: (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2] && !pin_level_q;
endmodule

// ---- aphc_top.sv ----
// Parallel-bus control side of a six-channel 12-bit successive-approximation converter.
`timescale 1ns/1ps
`include "aphc_regs.svh"

// Overview of operation
// - Chip select is active low; strobes are ignored while it is high.
// - Twelve-bit three-state data bus, bit eleven most significant, shared both ways.
// - In internal clock mode conversions run from an internal oscillator near 1.56 MHz.
// - Internal acquisition: write rising edge latches control byte, acquires, then converts.
// - External acquisition: first write rising edge opens the acquisition window.
// - External acquisition: second write rising edge ends acquisition and starts conversion.
// - Completion flag goes low when the conversion result is ready.
// - Read strobe falling edge with chip select low drives the result on the bus.
// - Read strobe low returns the completion flag high.
// - Control bit five picks internal (0) or host-ended (1) acquisition.
// - Internal acquisition lasts six converter clock cycles, then hold and convert.
// - Top two bits: external clock, internal clock, standby, full power-down.
// - Low three bits address one of six analog inputs, codes zero to five.
module aphc_top #(
	parameter int ACQ_CYCLES  = `APHC_ACQ_CYCLES,
	parameter int CONV_CYCLES = `APHC_CONV_BITS,
	parameter int HALF_CYCLES = `APHC_OSC_HALF_CYCLES
) (
	// Clock and reset.
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Host strobes.
	input  wire logic                 chip_sel_n,
	input  wire logic                 write_n,
	input  wire logic                 read_n,
	// Parallel data lines, split into input, output and output enable.
	input  wire logic [11:0]          parallel_data_lines_i,
	output logic      [11:0]          parallel_data_lines_o,
	output logic                      parallel_data_lines_oe_n,
	// Converter clock pin and completion flag.
	input  wire logic                 conv_clk_pin,
	output logic                      conv_done_n,
	// Converter core side.
	input  wire logic [11:0]          sar_result,
	output logic [2:0]                analog_inputs_sel,
	output logic                      channel_valid,
	output logic                      track_en,
	output logic                      convert_en,
	output logic                      range_sel,
	output logic                      bipolar_sel,
	output aphc_pkg::aphc_mode_type   power_mode,
	output logic                      standby_powerdown,
	output logic                      full_powerdown
);
	import aphc_pkg::*;

	aphc_tick_if tick_bus ();

	logic [2:0]     cs_sync_q;
	logic [2:0]     wr_sync_q;
	logic [2:0]     rd_sync_q;
	logic           cs_q;
	logic           wr_q;
	logic           rd_q;
	logic           wr_rise;
	logic           rd_fall;
	logic           rd_active;
	logic [7:0]     ctrl_q;
	logic           use_int_clk_q;
	aphc_state_type state_q;
	aphc_state_type state_d;
	logic [4:0]     cycle_cnt_q;
	logic [11:0]    result_q;
	logic [11:0]    read_data_q;
	logic           done_n_q;
	logic [7:0]     wr_byte;

	// Three-stage filter for an asynchronous pin; stage one feeds only stage two.
	function automatic logic filt(input logic [2:0] s, input logic held);
		filt = (s[1] == s[2]) ? s[2] : held;
	endfunction

	// =====================================================================
	// Pin synchronisers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync_q <= 3'h7;
			wr_sync_q <= 3'h7;
			rd_sync_q <= 3'h7;
			cs_q      <= 1'b1;
			wr_q      <= 1'b1;
			rd_q      <= 1'b1;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], chip_sel_n};
			wr_sync_q <= {wr_sync_q[1:0], write_n};
			rd_sync_q <= {rd_sync_q[1:0], read_n};
			cs_q      <= filt(cs_sync_q, cs_q);
			wr_q      <= filt(wr_sync_q, wr_q);
			rd_q      <= filt(rd_sync_q, rd_q);
		end
	end

	// Strobe edges count only with chip select low.
	assign wr_rise = filt(wr_sync_q, wr_q) && !wr_q && !filt(cs_sync_q, cs_q);
	assign rd_fall = !filt(rd_sync_q, rd_q) && rd_q && !filt(cs_sync_q, cs_q);
	assign rd_active = !cs_q && !rd_q;

	// Data lines are sampled directly, without synchronisers; only the low byte is taken, at the filtered write edge.
	assign wr_byte = parallel_data_lines_i[7:0];

	// =====================================================================
	// Control byte.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `APHC_CTRL_RESET;
		end else if (wr_rise && (state_q != APHC_ST_ACQ_EXT)) begin
			ctrl_q <= wr_byte;
		end
	end

	// Power-down codes keep the last clock choice.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			use_int_clk_q <= 1'b0;
		end else if (wr_rise && !wr_byte[`APHC_BIT_PWR_HI]) begin
			use_int_clk_q <= wr_byte[`APHC_BIT_PWR_LO];
		end
	end

	assign tick_bus.use_internal = use_int_clk_q;

	aphc_tick_gen #(
		.HALF_CYCLES (HALF_CYCLES)
	) u_tick (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.conv_clk_pin (conv_clk_pin),
		.tick_port    (tick_bus)
	);

	// =====================================================================
	// Acquisition and conversion sequencer.
	always_comb begin
		state_d = state_q;
		case (state_q)
			APHC_ST_IDLE, APHC_ST_DONE: begin
				if (wr_rise && !wr_byte[`APHC_BIT_PWR_HI]) begin
					state_d = wr_byte[`APHC_BIT_ACQ_MODE] ? APHC_ST_ACQ_EXT
						: APHC_ST_ACQ_INT;
				end
			end
			APHC_ST_ACQ_INT: begin
				if (tick_bus.tick && (cycle_cnt_q == 5'(ACQ_CYCLES - 1))) begin
					state_d = APHC_ST_CONVERT;
				end
			end
			APHC_ST_ACQ_EXT: begin
				if (wr_rise) begin
					state_d = APHC_ST_CONVERT;
				end
			end
			APHC_ST_CONVERT: begin
				if (tick_bus.tick && (cycle_cnt_q == 5'(CONV_CYCLES - 1))) begin
					state_d = APHC_ST_DONE;
				end
			end
			default: begin
				state_d = APHC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= APHC_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycle_cnt_q <= 5'h0;
		end else if (state_d != state_q) begin
			cycle_cnt_q <= 5'h0;
		end else if (tick_bus.tick) begin
			cycle_cnt_q <= cycle_cnt_q + 5'h1;
		end
	end

	// =====================================================================
	// Result capture and completion flag.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= 12'h000;
		end else if (state_q == APHC_ST_CONVERT && state_d == APHC_ST_DONE) begin
			result_q <= sar_result;
		end
	end

	// A new result wins over a read clear in the same cycle.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_n_q <= 1'b1;
		end else if (state_q == APHC_ST_CONVERT && state_d == APHC_ST_DONE) begin
			done_n_q <= 1'b0;
		end else if (rd_fall) begin
			done_n_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data_q <= 12'h000;
		end else if (rd_fall) begin
			read_data_q <= result_q;
		end
	end

	// =====================================================================
	// Outputs.
	assign parallel_data_lines_o    = read_data_q;
	assign parallel_data_lines_oe_n = !rd_active;
	assign conv_done_n              = done_n_q;
	assign analog_inputs_sel        = ctrl_q[`APHC_CHAN_MSB:`APHC_CHAN_LSB];
	assign channel_valid            = (ctrl_q[`APHC_CHAN_MSB:`APHC_CHAN_LSB] <= `APHC_CHAN_LAST);
	assign track_en    = (state_q == APHC_ST_ACQ_INT) || (state_q == APHC_ST_ACQ_EXT);
	assign convert_en  = (state_q == APHC_ST_CONVERT);
	assign range_sel   = ctrl_q[`APHC_BIT_RANGE];
	assign bipolar_sel = ctrl_q[`APHC_BIT_BIPOLAR];
	assign power_mode  = aphc_mode_type'(ctrl_q[`APHC_BIT_PWR_HI:`APHC_BIT_PWR_LO]);
	assign standby_powerdown = (power_mode == APHC_MODE_STANDBY);
	assign full_powerdown    = (power_mode == APHC_MODE_FULL_PD);
endmodule

// ---- aphc_host_model.sv ----
// Host processor model for the converter control block bus.
`timescale 1ns/1ps

module aphc_host_model (
	// Clock and bus seen by the host.
	input  wire logic        core_clk,
	input  wire logic [11:0] bus_in,
	// Host pins.
	output logic             cs_n,
	output logic             wr_n,
	output logic             rd_n,
	output logic      [11:0] bus_out,
	output logic             conv_clk
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		bus_out = 12'h0;
		conv_clk = 1'b0;
	end

	// The converter clock runs free at 5 MHz.
	always #100 conv_clk = ~conv_clk;

	// A released bus shows the inverse of the last byte, so stale data never matches.
	task automatic wr(input logic sel_n, input logic [7:0] b);
		@(negedge core_clk);
		cs_n = sel_n;
		bus_out = {4'h0, b};
		wr_n = 1'b0;
		repeat (6) @(negedge core_clk);
		wr_n = 1'b1;
		repeat (6) @(negedge core_clk);
		cs_n = 1'b1;
		bus_out = ~bus_out;
		repeat (6) @(negedge core_clk);
	endtask

	task automatic rd(output logic [11:0] v);
		@(negedge core_clk);
		cs_n = 1'b0;
		rd_n = 1'b0;
		repeat (6) @(negedge core_clk);
		v = bus_in;
		rd_n = 1'b1;
		cs_n = 1'b1;
		repeat (6) @(negedge core_clk);
	endtask
endmodule

// ---- aphc_top_monitor.sv ----
// Port checker for the converter control block.
`timescale 1ns/1ps

module aphc_top_monitor (
	// Clock, reset and host pins.
	input wire logic                    core_clk,
	input wire logic                    rst_n,
	input wire logic                    chip_sel_n,
	input wire logic                    read_n,
	// Block outputs.
	input wire logic                    parallel_data_lines_oe_n,
	input wire logic                    conv_done_n,
	input wire logic [2:0]              analog_inputs_sel,
	input wire logic                    channel_valid,
	input wire logic                    track_en,
	input wire logic                    convert_en,
	input wire aphc_pkg::aphc_mode_type power_mode,
	input wire logic                    standby_powerdown,
	input wire logic                    full_powerdown
);
	import aphc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_OE_CS: assert property (chip_sel_n [*6] |-> parallel_data_lines_oe_n)
		else $error("bus driven while deselected");
	AST_OE_ON: assert property ((!chip_sel_n && !read_n) [*6] |-> !parallel_data_lines_oe_n)
		else $error("bus not driven in read");
	AST_DONE_CLR: assert property ((!chip_sel_n && !read_n && !convert_en) [*7] |-> conv_done_n)
		else $error("flag not cleared by read");
	AST_DONE_SET: assert property ($fell(convert_en) |-> ##[0:1] !conv_done_n)
		else $error("flag not set after conversion");
	AST_ACQ_CONV: assert property ($fell(track_en) |-> ##[0:1] convert_en)
		else $error("no conversion after acquisition");
	AST_EXCL: assert property (!(track_en && convert_en))
		else $error("track and convert together");
	AST_CHAN: assert property (channel_valid == (analog_inputs_sel <= 3'h5))
		else $error("channel valid wrong");
	AST_STBY: assert property (standby_powerdown == (power_mode == APHC_MODE_STANDBY))
		else $error("standby flag wrong");
	AST_FULL: assert property (full_powerdown == (power_mode == APHC_MODE_FULL_PD))
		else $error("full power-down flag wrong");
endmodule

bind aphc_top aphc_top_monitor mon_u (
	.core_clk(core_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .read_n(read_n),
	.parallel_data_lines_oe_n(parallel_data_lines_oe_n), .conv_done_n(conv_done_n),
	.analog_inputs_sel(analog_inputs_sel), .channel_valid(channel_valid),
	.track_en(track_en), .convert_en(convert_en), .power_mode(power_mode),
	.standby_powerdown(standby_powerdown), .full_powerdown(full_powerdown)
);

// ---- aphc_top_bench.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps

module aphc_top_bench;
	import aphc_pkg::*;

	logic          core_clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          chip_sel_n, write_n, read_n, oe_n, conv_clk_pin, done_n;
	logic          track, conv, chv, stby, fpd, rng, bip;
	logic [2:0]    sel;
	logic [11:0]   bus, dut_o, host_o;
	logic [11:0]   sar = 12'h0;
	aphc_mode_type pm;
	int            bad_count = 0;
	int            checks_done = 0;
	int            trk_n = 0;

	always #12.5 core_clk = ~core_clk;
	always @(negedge core_clk) trk_n += (track === 1'b1);
	assign bus = oe_n ? host_o : dut_o;

	aphc_top #(.HALF_CYCLES(2)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .write_n(write_n),
		.read_n(read_n), .parallel_data_lines_i(bus), .parallel_data_lines_o(dut_o),
		.parallel_data_lines_oe_n(oe_n), .conv_clk_pin(conv_clk_pin), .conv_done_n(done_n),
		.sar_result(sar), .analog_inputs_sel(sel), .channel_valid(chv), .track_en(track),
		.convert_en(conv), .range_sel(rng), .bipolar_sel(bip), .power_mode(pm),
		.standby_powerdown(stby), .full_powerdown(fpd)
	);
	aphc_host_model host_u (
		.core_clk(core_clk), .bus_in(bus), .cs_n(chip_sel_n), .wr_n(write_n),
		.rd_n(read_n), .bus_out(host_o), .conv_clk(conv_clk_pin)
	);

	task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		while (done_n !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chk("done_flag", {11'h0, done_n}, 12'h0);
	endtask

	task automatic rd_chk(input logic [11:0] e);
		logic [11:0] v;
		host_u.rd(v);
		chk("result", v, e);
		chk("done_clear", {11'h0, done_n}, 12'h1);
		chk("bus_free", {11'h0, oe_n}, 12'h1);
	endtask

	// ==========================================
	// Scenarios.
	task automatic t_int;
		trk_n = 0;
		sar = 12'ha5c;
		host_u.wr(1'b0, 8'h42);
		wait_done;
		chk("acq_len", {11'h0, trk_n >= 20 && trk_n <= 28}, 12'h1);
		chk("chan", {9'h0, sel}, 12'h2);
		rd_chk(12'ha5c);
	endtask

	task automatic t_ext;
		sar = 12'h3c1;
		host_u.wr(1'b0, 8'h23);
		repeat (60) @(negedge core_clk);
		chk("ext_open", {10'h0, track, conv}, 12'h2);
		host_u.wr(1'b0, 8'h00);
		chk("ext_end", {10'h0, track, conv}, 12'h1);
		wait_done;
		chk("ext_chan", {9'h0, sel}, 12'h3);
		rd_chk(12'h3c1);
	endtask

	task automatic t_cs;
		trk_n = 0;
		host_u.wr(1'b1, 8'h45);
		chk("cs_track", trk_n[11:0], 12'h0);
		chk("cs_chan", {9'h0, sel}, 12'h3);
	endtask

	task automatic t_modes;
		logic [2:0] ch;
		for (int i = 0; i < 4; i++) begin
			ch = 3'(i + 4);
			sar = 12'h7f0 + i[11:0];
			host_u.wr(1'b0, {i[1:0], 1'b0, i[1], i[0], ch});
			chk("mode", {10'h0, pm}, i[11:0]);
			chk("rng_bip", {10'h0, rng, bip}, i[11:0]);
			chk("pd", {10'h0, fpd, stby}, {10'h0, i == 3, i == 2});
			chk("chan_ok", {11'h0, chv}, {11'h0, ch <= 3'h5});
			if (i < 2) begin
				wait_done;
				rd_chk(12'h7f0 + i[11:0]);
			end else begin
				chk("pd_idle", {11'h0, track}, 12'h0);
			end
		end
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk("reset", {oe_n, done_n, track, conv, pm, sel}, 12'h180);
		rst_n = 1'b1;
		t_int;
		t_ext;
		t_cs;
		t_modes;
		end_sim;
	end

	initial begin
		#1000000;
		bad_count++;
		end_sim;
	end
endmodule
